// ### src/byte_lane_counter.sv
// Multi-byte counter with independent byte writes and a terminal pulse
`timescale 1ns/10ps
module byte_lane_counter #(
  parameter int                 BYTES       = 2,
  parameter logic [8*BYTES-1:0] RESET_VALUE = '1
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               clear,
  input  wire logic               wr_en,
  input  wire logic [1:0]         wr_sel,
  input  wire logic [7:0]         wr_data,
  input  wire logic               step_en,
  input  wire logic               step_up,
  input  wire logic [7:0]         step_size,
  output logic      [8*BYTES-1:0] value,
  output logic                    expire
);

  // ==========================================================
  // Parameter check
  initial begin
    if (BYTES < 1 || BYTES > 4)
      $error("byte_lane_counter: BYTES must be 1 to 4");
  end

  localparam logic [8*BYTES-1:0] ONE = {{(8*BYTES-1){1'b0}}, 1'b1};

  // Down step from one lands on zero
  assign expire = step_en && !step_up && !wr_en && !clear
                  && (value == ONE);

  // ==========================================================
  // Counter; a host byte write replaces the step in that cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      value <= RESET_VALUE;
    end else if (clear) begin
      value <= '0;
    end else if (wr_en) begin
      for (int i = 0; i < BYTES; i++) begin
        if (wr_sel == 2'(i)) begin
          value[8*i +: 8] <= wr_data;
        end
      end
    end else if (step_en) begin
      if (step_up) begin
        value <= value + (8*BYTES)'(step_size);
      end else begin
        value <= value - ONE;
      end
    end
  end

endmodule

// ### src/xfer_count_regs.sv
// Record count, end-of-transfer, byte count and prearm register bank
// Contract
// - Hold an 11-bit decompression line length over two byte addresses.
// - 16-bit compression record count, resets to all ones, steps down.
// - Compression count reaching zero sets status bit 0.
// - Decompression count reaching zero sets status bit 1.
// - Status bits clear only on host write of one; reset zero.
// - Mask bits 0 and 1 block their flags from interrupt; reset all ones.
// - 16-bit decompression record count over two bytes, resets all ones.
// - Decompression count expiry posts the decompression done flag.
// - 32-bit output byte count, rounded to bus word, four bytes.
// - Byte count clears on record start and output FIFO reset.
// - Compression staged control layout, reset value 0x04.
// - Decompression staged control layout, reset value 0x00.
// - Blank record outputs the stored fill byte for the record.
// - Two test registers reset to zero; host writes only zero. The bank stores any byte the host writes to them.
// - Armed staged byte loads live control at empty end of record.
// - Blank control clears when decompression count reaches zero.
// - Pause on transfer clears compression enable at transfer end.
`timescale 1ns/10ps
module xfer_count_regs #(
  parameter int LINE_BITS = 11
) (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  // Processor port
  input  wire logic                          proc_select_n,
  input  wire logic                          proc_dir,
  input  wire logic                          proc_dir_read_level,
  input  wire logic [5:0]                    proc_addr,
  input  wire logic [7:0]                    proc_data_in,
  output logic      [7:0]                    proc_data_out,
  output logic                               proc_data_oe,
  output logic                               proc_ready_n,
  output logic                               irq_out_n,
  // Engine side
  input  wire xfer_regs_pkg::comp_events_t   comp_ev,
  input  wire xfer_regs_pkg::decomp_events_t decomp_ev,
  input  wire logic                          wide_bus,
  output logic      [7:0]                    comp_control,
  output logic      [7:0]                    decomp_control,
  output logic      [LINE_BITS-1:0]          decomp_line_length,
  output logic      [7:0]                    blank_fill_byte,
  output logic                               decomp_blank_record,
  output logic      [15:0]                   comp_records_left,
  output logic      [15:0]                   decomp_records_left,
  output logic      [31:0]                   compressed_bytes_out
);

  // ==========================================================
  // Parameter check
  initial begin
    if (LINE_BITS != 8 + xfer_regs_pkg::LINE_HI_BITS)
      $error("xfer_count_regs: LINE_BITS must be 11");
  end

  // ==========================================================
  // Access decode
  logic        select_q;
  logic        access;
  logic        wr;
  logic        rd;
  logic [7:0]  next_read_data;

  logic [7:0]  comp_staged;
  logic [7:0]  decomp_staged;
  logic [7:0]  test_low;
  logic [7:0]  test_high;
  logic [7:0]  eot_status;
  logic [7:0]  eot_mask;
  logic        comp_rc_expire;
  logic        decomp_rc_expire;
  logic        comp_pause_transfer;

  // Only the falling edge of select starts an access, so a select
  // held low for several cycles is still one access
  assign access = !proc_select_n && select_q;
  assign wr     = access && (proc_dir != proc_dir_read_level);
  assign rd     = access && (proc_dir == proc_dir_read_level);

  function automatic logic wr_to(input logic       w,
                                 input logic [5:0] a,
                                 input logic [5:0] target);
    return w && (a == target);
  endfunction

  function automatic logic [7:0] lane(input logic [31:0] v,
                                      input logic [1:0]  idx);
    return v[8*idx +: 8];
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      select_q <= 1'b1;
    end else begin
      select_q <= proc_select_n;
    end
  end

  // ==========================================================
  // Read answer: data and ready one cycle after the access
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      proc_data_out <= 8'h00;
      proc_data_oe  <= 1'b0;
      proc_ready_n  <= 1'b1;
    end else begin
      proc_ready_n <= !access;
      proc_data_oe <= rd;
      if (rd) begin
        proc_data_out <= next_read_data;
      end
    end
  end

  // ==========================================================
  // Record counters
  byte_lane_counter #(
    .BYTES       (2),
    .RESET_VALUE (xfer_regs_pkg::RST_RECORD_COUNT)
  ) comp_rc_cnt (
    .clk       (clk),
    .rst_b     (rst_b),
    .clear     (1'b0),
    .wr_en     (wr && proc_addr[5:1] == xfer_regs_pkg::ADDR_COMP_RC[5:1]),
    .wr_sel    ({1'b0, proc_addr[0]}),
    .wr_data   (proc_data_in),
    .step_en   (comp_ev.record_end_in),
    .step_up   (1'b0),
    .step_size (8'h01),
    .value     (comp_records_left),
    .expire    (comp_rc_expire)
  );

  byte_lane_counter #(
    .BYTES       (2),
    .RESET_VALUE (xfer_regs_pkg::RST_RECORD_COUNT)
  ) decomp_rc_cnt (
    .clk       (clk),
    .rst_b     (rst_b),
    .clear     (1'b0),
    .wr_en     (wr &&
                proc_addr[5:1] == xfer_regs_pkg::ADDR_DECOMP_RC[5:1]),
    .wr_sel    ({1'b0, proc_addr[0]}),
    .wr_data   (proc_data_in),
    .step_en   (decomp_ev.record_end_in),
    .step_up   (1'b0),
    .step_size (8'h01),
    .value     (decomp_records_left),
    .expire    (decomp_rc_expire)
  );

  // ==========================================================
  // Compressed byte counter, counted in whole bus words
  byte_lane_counter #(
    .BYTES       (4),
    .RESET_VALUE (xfer_regs_pkg::RST_BYTE_CNT)
  ) byte_cnt (
    .clk       (clk),
    .rst_b     (rst_b),
    .clear     (comp_ev.record_start ||
                comp_ev.out_fifo_reset),
    .wr_en     (wr &&
                proc_addr[5:2] == xfer_regs_pkg::ADDR_BYTE_CNT[5:2]),
    .wr_sel    (proc_addr[1:0]),
    .wr_data   (proc_data_in),
    .step_en   (comp_ev.out_word),
    .step_up   (1'b1),
    .step_size (wide_bus ? xfer_regs_pkg::WORD_BYTES_WIDE
                         : xfer_regs_pkg::WORD_BYTES_NARROW),
    .value     (compressed_bytes_out),
    .expire    ()
  );

  // ==========================================================
  // End-of-transfer status and mask
  logic [7:0] eot_set;
  logic [7:0] eot_clear;

  always_comb begin
    eot_set = 8'h00;
    eot_set[xfer_regs_pkg::EOT_COMP_BIT]   = comp_rc_expire;
    // Decompression expiry drives its own flag, not the compression one
    eot_set[xfer_regs_pkg::EOT_DECOMP_BIT] = decomp_rc_expire;
    eot_clear = 8'h00;
    if (wr_to(wr, proc_addr, xfer_regs_pkg::ADDR_EOT_STATUS)) begin
      eot_clear = proc_data_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      eot_status <= xfer_regs_pkg::RST_EOT_STATUS;
    end else begin
      // Set wins so an event landing on a clear is kept
      eot_status <= ((eot_status & ~eot_clear) | eot_set) & 8'h03;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      eot_mask <= xfer_regs_pkg::RST_EOT_MASK;
    end else if (wr_to(wr, proc_addr, xfer_regs_pkg::ADDR_EOT_MASK)) begin
      eot_mask <= proc_data_in;
    end
  end

  // Registered so the pin never glitches on decode
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~|(eot_status[1:0] & ~eot_mask[1:0]);
    end
  end

  // ==========================================================
  // Decompression line length and fill byte
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      decomp_line_length <= xfer_regs_pkg::RST_LINE;
    end else begin
      if (wr_to(wr, proc_addr, xfer_regs_pkg::ADDR_LINE_LO)) begin
        decomp_line_length[7:0] <= proc_data_in;
      end
      if (wr_to(wr, proc_addr, xfer_regs_pkg::ADDR_LINE_HI)) begin
        decomp_line_length[LINE_BITS-1:8] <=
          proc_data_in[xfer_regs_pkg::LINE_HI_BITS-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      blank_fill_byte <= xfer_regs_pkg::RST_FILL;
    end else if (wr_to(wr, proc_addr, xfer_regs_pkg::ADDR_FILL)) begin
      blank_fill_byte <= proc_data_in;
    end
  end

  // ==========================================================
  // Staged control bytes and test registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      comp_staged   <= xfer_regs_pkg::RST_COMP_STAGED;
      decomp_staged <= xfer_regs_pkg::RST_DECOMP_STAGED;
    end else begin
      if (wr_to(wr, proc_addr, xfer_regs_pkg::ADDR_COMP_STAGED)) begin
        comp_staged <= proc_data_in;
      end
      if (wr_to(wr, proc_addr, xfer_regs_pkg::ADDR_DECOMP_STAGED)) begin
        decomp_staged <= proc_data_in;
      end
    end
  end

  // Test bytes only store; nothing in the bank acts on them
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      test_low  <= xfer_regs_pkg::RST_TEST;
      test_high <= xfer_regs_pkg::RST_TEST;
    end else begin
      if (wr_to(wr, proc_addr, xfer_regs_pkg::ADDR_TEST_LOW)) begin
        test_low <= proc_data_in;
      end
      if (wr_to(wr, proc_addr, xfer_regs_pkg::ADDR_TEST_HIGH)) begin
        test_high <= proc_data_in;
      end
    end
  end

  // ==========================================================
  // Live compression control
  // Prearm waits for an empty engine so no buffered data is corrupted
  logic comp_prearm;
  logic comp_stop;

  assign comp_pause_transfer = comp_control[xfer_regs_pkg::CTL_PAUSE_XFER];
  assign comp_prearm = comp_control[xfer_regs_pkg::CTL_ARM]
                       && comp_ev.record_end_out
                       && comp_ev.engine_empty;
  assign comp_stop = (comp_pause_transfer && comp_rc_expire)
                     || (comp_control[xfer_regs_pkg::CTL_PAUSE_REC]
                         && comp_ev.record_end_in);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      comp_control <= xfer_regs_pkg::RST_COMP_CTRL;
    end else begin
      if (wr_to(wr, proc_addr, xfer_regs_pkg::ADDR_COMP_CTRL)) begin
        comp_control <= proc_data_in;
      end else if (comp_prearm) begin
        comp_control <= comp_staged;
      end else if (comp_stop) begin
        comp_control[xfer_regs_pkg::CTL_ENABLE] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Live decompression control
  logic decomp_prearm;
  logic decomp_stop;

  assign decomp_prearm = decomp_control[xfer_regs_pkg::CTL_ARM]
                         && decomp_ev.record_end_out
                         && decomp_ev.engine_empty;
  assign decomp_stop =
    (decomp_control[xfer_regs_pkg::CTL_PAUSE_XFER] && decomp_rc_expire)
    || (decomp_control[xfer_regs_pkg::CTL_PAUSE_REC]
        && decomp_ev.record_end_in);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      decomp_control <= xfer_regs_pkg::RST_DECOMP_CTRL;
    end else begin
      if (wr_to(wr, proc_addr, xfer_regs_pkg::ADDR_DECOMP_CTRL)) begin
        decomp_control <= proc_data_in;
      end else if (decomp_prearm) begin
        decomp_control <= decomp_staged;
      end else begin
        if (decomp_stop) begin
          decomp_control[xfer_regs_pkg::CTL_ENABLE] <= 1'b0;
        end
        if (decomp_rc_expire) begin
          decomp_control[xfer_regs_pkg::CTL_BLANK] <= 1'b0;
        end
      end
    end
  end

  assign decomp_blank_record = decomp_control[xfer_regs_pkg::CTL_BLANK];

  // ==========================================================
  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    next_read_data = 8'h00;
    case (proc_addr)
      xfer_regs_pkg::ADDR_COMP_CTRL: begin
        next_read_data = comp_control;
        next_read_data[xfer_regs_pkg::CTL_EMPTY] = comp_ev.engine_empty;
      end
      xfer_regs_pkg::ADDR_DECOMP_CTRL: begin
        next_read_data = decomp_control;
        next_read_data[xfer_regs_pkg::CTL_EMPTY] = decomp_ev.engine_empty;
      end
      xfer_regs_pkg::ADDR_TEST_LOW:      next_read_data = test_low;
      xfer_regs_pkg::ADDR_TEST_HIGH:     next_read_data = test_high;
      xfer_regs_pkg::ADDR_LINE_LO: begin
        next_read_data = decomp_line_length[7:0];
      end
      xfer_regs_pkg::ADDR_LINE_HI: begin
        next_read_data = 8'(decomp_line_length[LINE_BITS-1:8]);
      end
      xfer_regs_pkg::ADDR_COMP_RC: begin
        next_read_data = lane({16'h0000, comp_records_left}, 2'd0);
      end
      xfer_regs_pkg::ADDR_COMP_RC + 6'h01: begin
        next_read_data = lane({16'h0000, comp_records_left}, 2'd1);
      end
      xfer_regs_pkg::ADDR_DECOMP_RC: begin
        next_read_data = lane({16'h0000, decomp_records_left}, 2'd0);
      end
      xfer_regs_pkg::ADDR_DECOMP_RC + 6'h01: begin
        next_read_data = lane({16'h0000, decomp_records_left}, 2'd1);
      end
      xfer_regs_pkg::ADDR_EOT_STATUS:    next_read_data = eot_status;
      xfer_regs_pkg::ADDR_EOT_MASK:      next_read_data = eot_mask;
      xfer_regs_pkg::ADDR_BYTE_CNT,
      xfer_regs_pkg::ADDR_BYTE_CNT + 6'h01,
      xfer_regs_pkg::ADDR_BYTE_CNT + 6'h02,
      xfer_regs_pkg::ADDR_BYTE_CNT + 6'h03: begin
        next_read_data = lane(compressed_bytes_out, proc_addr[1:0]);
      end
      xfer_regs_pkg::ADDR_COMP_STAGED:   next_read_data = comp_staged;
      xfer_regs_pkg::ADDR_FILL:          next_read_data = blank_fill_byte;
      xfer_regs_pkg::ADDR_DECOMP_STAGED: next_read_data = decomp_staged;
      default:                           next_read_data = 8'h00;
    endcase
  end

endmodule

// ### src/xfer_regs_pkg.sv
// Register map, field layout and event carriers of the transfer register bank
package xfer_regs_pkg;

  // ==========================================================
  // Register offsets on the byte-wide processor port
  localparam logic [5:0] ADDR_COMP_CTRL      = 6'h14;
  localparam logic [5:0] ADDR_DECOMP_CTRL    = 6'h18;
  localparam logic [5:0] ADDR_TEST_LOW       = 6'h1a;
  localparam logic [5:0] ADDR_LINE_LO        = 6'h1c;
  localparam logic [5:0] ADDR_LINE_HI        = 6'h1d;
  localparam logic [5:0] ADDR_COMP_RC        = 6'h20;
  localparam logic [5:0] ADDR_EOT_STATUS     = 6'h27;
  localparam logic [5:0] ADDR_EOT_MASK       = 6'h29;
  localparam logic [5:0] ADDR_DECOMP_RC      = 6'h2c;
  localparam logic [5:0] ADDR_BYTE_CNT       = 6'h30;
  localparam logic [5:0] ADDR_COMP_STAGED    = 6'h34;
  localparam logic [5:0] ADDR_FILL           = 6'h35;
  localparam logic [5:0] ADDR_DECOMP_STAGED  = 6'h38;
  localparam logic [5:0] ADDR_TEST_HIGH      = 6'h3a;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  RST_COMP_CTRL      = 8'h04;
  localparam logic [7:0]  RST_DECOMP_CTRL    = 8'h04;
  localparam logic [7:0]  RST_TEST           = 8'h00;
  localparam logic [10:0] RST_LINE           = 11'h000;
  localparam logic [15:0] RST_RECORD_COUNT   = 16'hffff;
  localparam logic [7:0]  RST_EOT_STATUS     = 8'h00;
  localparam logic [7:0]  RST_EOT_MASK       = 8'hff;
  localparam logic [31:0] RST_BYTE_CNT       = 32'h0000_0000;
  localparam logic [7:0]  RST_COMP_STAGED    = 8'h04;
  localparam logic [7:0]  RST_FILL           = 8'h00;
  localparam logic [7:0]  RST_DECOMP_STAGED  = 8'h00;

  // ==========================================================
  // Control byte fields, shared by live and staged copies
  localparam int CTL_ARM        = 7;
  localparam int CTL_BLANK      = 6;
  localparam int CTL_PAUSE_XFER = 5;
  localparam int CTL_PASS       = 4;
  localparam int CTL_DICT_RESET = 3;
  localparam int CTL_EMPTY      = 2;
  localparam int CTL_ENABLE     = 1;
  localparam int CTL_PAUSE_REC  = 0;

  // End-of-transfer status and mask fields
  localparam int EOT_COMP_BIT   = 0;
  localparam int EOT_DECOMP_BIT = 1;

  // Line length upper byte carries three bits
  localparam int LINE_HI_BITS   = 3;

  // Bytes per output word for the byte counter rounding
  localparam logic [7:0] WORD_BYTES_WIDE   = 8'h04;
  localparam logic [7:0] WORD_BYTES_NARROW = 8'h02;

  // ==========================================================
  // Event carriers from the engines
  typedef struct packed {
    logic record_end_in;
    logic record_end_out;
    logic engine_empty;
    logic out_word;
    logic out_fifo_reset;
    logic record_start;
  } comp_events_t;

  typedef struct packed {
    logic record_end_in;
    logic record_end_out;
    logic engine_empty;
  } decomp_events_t;

endpackage

// ### verification/proc_host.sv
// Processor partner on the byte-wide register port
`timescale 1ns/10ps
module proc_host (
  input  wire logic       clk,
  input  wire logic       ready_n,
  output logic            select_n,
  output logic            dir,
  output logic      [5:0] addr,
  output logic      [7:0] data_in
);
  initial begin
    select_n = 1'b1;
    dir = 1'b1;
    addr = 6'h00;
    data_in = 8'h00;
  end
  // Read level is one; select returns high between accesses so each
  // access is a fresh falling edge
  task automatic xfer(input logic wr, input logic [5:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    select_n = 1'b0;
    dir = ~wr;
    addr = a;
    data_in = wr ? d : ~data_in;
    do begin
      @(posedge clk);
      n++;
    end while (ready_n !== 1'b0 && n < 4);
    @(negedge clk);
    select_n = 1'b1;
    // Released data never keeps the last value
    data_in = ~data_in;
  endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the transfer register bank
`timescale 1ns/10ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wide = 1'b1;
  logic        sel_n, dir, oe, rdy_n, irq_n, blank;
  logic [5:0]  addr;
  logic [7:0]  din, dout, cctl, dctl, fill, v;
  logic [10:0] line;
  logic [15:0] crl, drl;
  logic [31:0] compressed_byte_counter;
  xfer_regs_pkg::comp_events_t   ce = 6'b001000;
  xfer_regs_pkg::decomp_events_t de = 3'b001;
  logic [7:0]  exp_q[$];
  logic [5:0]  adr_q[$];
  int          n_errors = 0;
  int          checked = 0;
  logic [5:0]  ra[12] = '{6'h1a, 6'h20, 6'h21, 6'h27, 6'h29, 6'h2c,
                          6'h2d, 6'h30, 6'h34, 6'h38, 6'h3a, 6'h3f};
  logic [7:0]  rv[12] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff,
                          8'hff, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
  always #20 clk = ~clk;
  proc_host host (.clk(clk), .ready_n(rdy_n), .select_n(sel_n),
                  .dir(dir), .addr(addr), .data_in(din));
  xfer_count_regs dut (.clk(clk), .rst_b(rst_b), .proc_select_n(sel_n),
    .proc_dir(dir), .proc_dir_read_level(1'b1), .proc_addr(addr),
    .proc_data_in(din), .proc_data_out(dout), .proc_data_oe(oe),
    .proc_ready_n(rdy_n), .irq_out_n(irq_n), .comp_ev(ce), .decomp_ev(de),
    .wide_bus(wide), .comp_control(cctl), .decomp_control(dctl),
    .decomp_line_length(line), .blank_fill_byte(fill),
    .decomp_blank_record(blank), .comp_records_left(crl),
    .decomp_records_left(drl), .compressed_bytes_out(compressed_byte_counter));
  // ==========
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    adr_q.push_back(a);
    host.xfer(1'b0, a, 8'h00);
  endtask
  // Engine pulses last one cycle; engine_empty rests high
  task automatic ev(input logic [5:0] c, input logic [2:0] d);
    @(negedge clk);
    ce = c;
    de = d;
    @(negedge clk);
    ce = 6'b001000;
    de = 3'b001;
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(negedge clk) begin
    if (oe === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("FAIL read expected none seen %h", dout);
      end else begin
        check($sformatf("reg %h", adr_q.pop_front()), 32'(dout),
              32'(exp_q.pop_front()));
      end
    end
  end
  initial begin
    #400000;
    n_errors++;
    $display("FAIL watchdog expected done seen timeout");
    print_verdict();
  end
  // ==========
  // Tests
  initial begin
    void'($urandom(32'h6248739b));
    repeat (8) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    $display("reset values done");
    v = 8'($urandom);
    wr(6'h1c, v);
    wr(6'h1d, 8'h05);
    check("line", 32'(line), {21'h0, 3'h5, v});
    rd(6'h1c, v);
    rd(6'h1d, 8'h05);
    $display("line length done");
    wr(6'h29, 8'h00);
    wr(6'h14, 8'h22);
    wr(6'h20, 8'h02);
    wr(6'h21, 8'h00);
    ev(6'b101000, 3'b001);
    check("comp count", 32'(crl), 32'h1);
    ev(6'b101000, 3'b001);
    check("comp ctl", 32'(cctl), 32'h20);
    repeat (2) @(negedge clk);
    check("irq", 32'(irq_n), 32'h0);
    rd(6'h27, 8'h01);
    wr(6'h27, 8'h00);
    rd(6'h27, 8'h01);
    wr(6'h29, 8'h01);
    check("irq masked", 32'(irq_n), 32'h1);
    wr(6'h27, 8'h01);
    rd(6'h27, 8'h00);
    $display("compression transfer done");
    wr(6'h2c, 8'h01);
    wr(6'h2d, 8'h00);
    wr(6'h18, 8'h40);
    check("blank set", 32'(blank), 32'h1);
    ev(6'b001000, 3'b101);
    check("blank end", 32'(blank), 32'h0);
    check("decomp count", 32'(drl), 32'h0);
    repeat (2) @(negedge clk);
    check("irq decomp", 32'(irq_n), 32'h0);
    rd(6'h27, 8'h02);
    wr(6'h27, 8'h02);
    $display("decompression transfer done");
    ev(6'b001001, 3'b001);
    repeat (3) ev(6'b001100, 3'b001);
    wide = 1'b0;
    ev(6'b001100, 3'b001);
    rd(6'h30, 8'h0e);
    rd(6'h31, 8'h00);
    ev(6'b001010, 3'b001);
    check("bytes", compressed_byte_counter, 32'h0);
    $display("byte count done");
    wr(6'h14, 8'h80);
    wr(6'h34, 8'h02);
    ev(6'b010000, 3'b001);
    check("ctl busy", 32'(cctl), 32'h80);
    ev(6'b011000, 3'b001);
    check("ctl armed", 32'(cctl), 32'h02);
    v = 8'($urandom);
    wr(6'h35, v);
    check("fill", 32'(fill), 32'(v));
    rd(6'h35, v);
    $display("prearm and fill done");
    repeat (3) @(negedge clk);
    print_verdict();
  end
endmodule

// ### verification/xfer_count_regs_monitor.sv
// Port checker for the transfer register bank
`timescale 1ns/10ps
module xfer_count_regs_monitor (
  input wire logic                          clk,
  input wire logic                          rst_b,
  input wire logic                          proc_select_n,
  input wire xfer_regs_pkg::comp_events_t   comp_ev,
  input wire xfer_regs_pkg::decomp_events_t decomp_ev,
  input wire logic                          wide_bus,
  input wire logic [7:0]                    comp_control,
  input wire logic [7:0]                    decomp_control,
  input wire logic                          decomp_blank_record,
  input wire logic [15:0]                   comp_records_left,
  input wire logic [15:0]                   decomp_records_left,
  input wire logic [31:0]                   compressed_bytes_out
);
  // ==========
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A host access may rewrite a counter, so only idle port cycles count
  comp_step_a: assert property (
    proc_select_n && comp_ev.record_end_in |=>
    comp_records_left == $past(comp_records_left) - 16'h1)
    else $error("compression record count did not step down");
  comp_hold_a: assert property (
    proc_select_n && !comp_ev.record_end_in |=> $stable(comp_records_left))
    else $error("compression record count moved without cause");
  decomp_step_a: assert property (
    proc_select_n && decomp_ev.record_end_in |=>
    decomp_records_left == $past(decomp_records_left) - 16'h1)
    else $error("decompression record count did not step down");
  byte_add_a: assert property (
    proc_select_n && comp_ev.out_word && !comp_ev.record_start &&
    !comp_ev.out_fifo_reset |=> compressed_bytes_out ==
    $past(compressed_bytes_out) + ($past(wide_bus) ? 32'h4 : 32'h2))
    else $error("byte count did not add one word");
  byte_clear_a: assert property (
    comp_ev.record_start || comp_ev.out_fifo_reset |=>
    compressed_bytes_out == 32'h0)
    else $error("byte count not cleared");
  pause_stop_a: assert property (
    proc_select_n && comp_control[5] && comp_records_left == 16'h1 &&
    comp_ev.record_end_in && !comp_ev.record_end_out |=> !comp_control[1])
    else $error("enable kept at transfer end");
  blank_end_a: assert property (
    proc_select_n && decomp_control[6] && decomp_records_left == 16'h1 &&
    decomp_ev.record_end_in && !decomp_ev.record_end_out
    |=> !decomp_blank_record)
    else $error("blank record control kept at transfer end");
  blank_mirror_a: assert property (
    decomp_blank_record == decomp_control[6])
    else $error("blank record output differs from control");
endmodule

bind xfer_count_regs xfer_count_regs_monitor mon (.clk(clk), .rst_b(rst_b),
  .proc_select_n(proc_select_n), .comp_ev(comp_ev),
  .decomp_ev(decomp_ev), .wide_bus(wide_bus),
  .comp_control(comp_control), .decomp_control(decomp_control),
  .decomp_blank_record(decomp_blank_record),
  .comp_records_left(comp_records_left),
  .decomp_records_left(decomp_records_left),
  .compressed_bytes_out(compressed_bytes_out));
